// File: bench/sdb_disk_model.sv
module sdb_disk_model (
  input wire logic mclk,
  input wire logic slow,
  input wire logic [15:0] blk_size,
  input wire logic disk_req,
  input wire logic [31:0] disk_lba,
  input wire logic disk_rdy,
  output logic disk_valid,
  output logic [7:0] disk_byte,
  input wire logic dfl_sel,
  input wire logic [15:0] dfl_addr,
  output logic [7:0] dfl_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic act_r = 1'b0;
  logic ph_r = 1'b0;
  logic [15:0] idx_r = 16'h0000;
  logic [31:0] lba_r = 32'h0000_0000;
  logic [7:0] last_r = 8'h00;
  // slow mode offers a byte only every other cycle
  assign disk_valid = act_r && (!slow || ph_r);
  // off-frame data is the inverse of the last byte, so stale data never looks good
  assign disk_byte = disk_valid ? {lba_r[3:0], idx_r[3:0]} : ~last_r;
  // lists answer in the same cycle; grown list An, primary list Cn
  assign dfl_data = dfl_sel ? 8'hA0 + dfl_addr[7:0] : 8'hC0 + dfl_addr[7:0];
  always_ff @(posedge mclk)
  begin
    ph_r <= ~ph_r;
    if (disk_req)
    begin
      act_r <= 1'b1;
      lba_r <= disk_lba;
      idx_r <= 16'h0000;
    end
    else if (disk_valid && disk_rdy)
    begin
      last_r <= disk_byte;
      idx_r <= idx_r + 16'h0001;
      act_r <= idx_r != blk_size - 16'h0001;
    end
  end
endmodule : sdb_disk_model

// File: bench/search_defect_buffer_cmds_tb.sv
module search_defect_buffer_cmds_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] BS = 16'h0004;
  logic mclk, nrst, cmd_start, bus_par_err, out_valid, out_rdy, in_valid, in_ready, slow;
  logic disk_req, disk_valid, disk_rdy, dfl_sel, dfl_unreadable, dfl_missing;
  logic busy, done, sense_valid;
  logic [79:0] cmd_cdb;
  logic [7:0] out_byte, in_byte, disk_byte, dfl_data, status, sense_code;
  logic [15:0] dfl_addr, dfl_plen, dfl_glen;
  logic [31:0] disk_lba, sense_info;
  logic [3:0] sense_key;
  logic [7:0] oq[$];
  logic [7:0] iq[$];
  logic [7:0] exq[$];
  int err_total = 0;
  int cmp_count = 0;
  int ntake, nreq;
  sdb_cmd i_dut (.mclk(mclk), .nrst(nrst), .ce(1'b1), .cmd_start(cmd_start),
    .cmd_cdb(cmd_cdb), .bus_par_err(bus_par_err), .blk_size(BS), .out_valid(out_valid),
    .out_byte(out_byte), .out_rdy(out_rdy), .in_valid(in_valid), .in_byte(in_byte),
    .in_ready(in_ready), .disk_req(disk_req), .disk_lba(disk_lba), .disk_valid(disk_valid),
    .disk_byte(disk_byte), .disk_rdy(disk_rdy), .disk_err(1'b0), .disk_err_code(8'h00),
    .disk_err_key(4'h0), .dfl_sel(dfl_sel), .dfl_addr(dfl_addr), .dfl_data(dfl_data),
    .dfl_plen(dfl_plen), .dfl_glen(dfl_glen), .dfl_unreadable(dfl_unreadable),
    .dfl_missing(dfl_missing), .busy(busy), .done(done), .status(status),
    .sense_valid(sense_valid), .sense_key(sense_key), .sense_code(sense_code),
    .sense_info(sense_info));
  sdb_disk_model i_disk (.mclk(mclk), .slow(slow), .blk_size(BS), .disk_req(disk_req),
    .disk_lba(disk_lba), .disk_rdy(disk_rdy), .disk_valid(disk_valid),
    .disk_byte(disk_byte), .dfl_sel(dfl_sel), .dfl_addr(dfl_addr), .dfl_data(dfl_data));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  function automatic logic [79:0] mk(input logic [7:0] op, input logic [7:0] b1,
    input logic [31:0] a, input logic [15:0] n);
    return {op, b1, a, 8'h00, n, 8'h00};
  endfunction : mk
  task automatic parm(input logic [31:0] rc, input logic [15:0] al, input logic [7:0] p0);
    logic [159:0] h;
    h = {16'h0000, BS, 32'h0, rc, al, 32'h0, BS};
    oq.delete();
    for (int i = 19; i >= 0; i--) oq.push_back(h[8*i +: 8]);
    for (int i = 0; i < 4; i++) oq.push_back(p0 + 8'(i));
  endtask : parm
  // issues one command, feeds oq, collects in-bound bytes while stalling every other cycle
  task automatic run(input logic [79:0] c, input logic pe);
    int n;
    logic tk;
    iq.delete();
    ntake = 0;
    nreq = 0;
    @(posedge mclk);
    #1 cmd_cdb = c;
    bus_par_err = pe;
    cmd_start = 1'b1;
    @(posedge mclk);
    #1 cmd_start = 1'b0;
    bus_par_err = 1'b0;
    for (n = 0; n < 9000; n++)
    begin
      @(negedge mclk);
      tk = out_valid && out_rdy === 1'b1;
      ntake += int'(tk);
      if (in_valid === 1'b1 && in_ready) iq.push_back(in_byte);
      nreq += int'(disk_req === 1'b1);
      if (done === 1'b1) break;
      @(posedge mclk);
      #1 if (tk) void'(oq.pop_front());
      out_valid = oq.size() != 0;
      out_byte = out_valid ? oq[0] : ~out_byte;
      in_ready = ~in_ready;
    end
    if (n == 9000) err_total++;
    chk(busy, 1'b0);
    @(posedge mclk);
    #1 out_valid = 1'b0;
  endtask : run
  logic [79:0] ec[5];
  logic [19:0] ex[5];
  logic [7:0] db2[5];
  logic [15:0] dal[5];
  int ds[5], dn[5];
  initial
  begin
    {nrst, cmd_start, bus_par_err, out_valid, slow, dfl_unreadable, dfl_missing} = '0;
    {cmd_cdb, out_byte} = '0;
    in_ready = 1'b1;
    dfl_plen = 16'h0003;
    dfl_glen = 16'h0002;
    repeat (8) @(posedge mclk);
    #1 nrst = 1'b1;
    slow = 1'b1;
    parm(32'h8, BS + 16'h0006, 8'h50);
    run(mk(8'h31, 8'h00, 32'h2, 16'h8), 1'b0);
    chk(status, 8'h04);
    chk(nreq, 4);
    chk({sense_valid, sense_info}, {1'b1, 32'h5});
    slow = 1'b0;
    parm(32'h8, BS + 16'h0006, 8'h20);
    run(mk(8'h31, 8'h10, 32'h2, 16'h8), 1'b0);
    chk({status, sense_info}, {8'h04, 32'h3});
    parm(32'h3, BS + 16'h0006, 8'hE0);
    run(mk(8'h31, 8'h00, 32'h2, 16'h8), 1'b0);
    chk(status, 8'h00);
    chk(nreq, 3);
    chk({sense_valid, sense_key, sense_code}, 13'h0000);
    parm(32'h8, BS + 16'h0005, 8'h50);
    run(mk(8'h31, 8'h00, 32'h2, 16'h8), 1'b0);
    chk({status, sense_key, sense_code}, 20'h02526);
    $display("search tests done");
    ec = '{mk(8'h31, 8'h00, 32'h2, 16'h0), mk(8'h37, 8'h20, 32'h1C00_0000, 16'h10),
      mk(8'h37, 8'h00, 32'h1D00_0000, 16'h10), mk(8'h3B, 8'h00, 32'h0, 16'h6),
      mk(8'h12, 8'h00, 32'h0, 16'h0)};
    ex = '{20'h02524, 20'h02525, 20'h02524, 20'h02447, 20'h02520};
    for (int k = 0; k < 5; k++)
    begin
      oq.delete();
      run(ec[k], k == 3);
      chk({status, sense_key, sense_code}, ex[k]);
    end
    $display("error tests done");
    exq = {8'h00, 8'h10, 8'h00, 8'h03, 8'hC0, 8'hC1, 8'hC2,
      8'h00, 8'h08, 8'h00, 8'h02, 8'hA0, 8'hA1};
    db2 = '{8'h1C, 8'h14, 8'h0C, 8'h1C, 8'h1C};
    dal = '{16'h0064, 16'h0064, 16'h0064, 16'h0006, 16'h0000};
    ds = '{0, 0, 7, 0, 0};
    dn = '{13, 7, 6, 6, 0};
    for (int k = 0; k < 5; k++)
    begin
      run(mk(8'h37, 8'h00, {db2[k], 24'h0}, dal[k]), 1'b0);
      chk({iq.size(), status}, {dn[k], 8'h00});
      for (int i = 0; i < dn[k] && i < iq.size(); i++) chk(iq[i], exq[ds[k] + i]);
    end
    dfl_unreadable = 1'b1;
    run(mk(8'h37, 8'h00, 32'h1C00_0000, 16'h10), 1'b0);
    chk({status, sense_key, sense_code}, 20'h02119);
    dfl_unreadable = 1'b0;
    dfl_missing = 1'b1;
    run(mk(8'h37, 8'h00, 32'h1C00_0000, 16'h10), 1'b0);
    chk({status, sense_key, sense_code}, 20'h0211C);
    dfl_missing = 1'b0;
    $display("defect tests done");
    dal = '{16'h0006, 16'h0000, 16'h2005, 16'h0000, 16'h0000};
    dn = '{6, 0, 8192, 0, 0};
    for (int k = 0; k < 3; k++)
    begin
      oq.delete();
      for (int i = 0; i < 8200; i++) oq.push_back(8'(i));
      run(mk(8'h3B, 8'h00, 32'h0, dal[k]), 1'b0);
      chk({ntake, status}, {dn[k], 8'h00});
    end
    $display("buffer tests done");
    test_done();
  end
  initial
  begin
    repeat (40000) @(posedge mclk);
    err_total++;
    test_done();
  end
endmodule : search_defect_buffer_cmds_tb

// File: hw/sdb_cmd.sv
`include "sdb_consts.svh"
module sdb_cmd #(
  parameter int AW = 13,
  parameter logic [15:0] BUF_BYTES = `SDB_BUF_BYTES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic cmd_start,
  input wire logic [79:0] cmd_cdb,
  input wire logic bus_par_err,
  input wire logic [15:0] blk_size,
  input wire logic out_valid,
  input wire logic [7:0] out_byte,
  output logic out_rdy,
  output logic in_valid,
  output logic [7:0] in_byte,
  input wire logic in_ready,
  output logic disk_req,
  output logic [31:0] disk_lba,
  input wire logic disk_valid,
  input wire logic [7:0] disk_byte,
  output logic disk_rdy,
  input wire logic disk_err,
  input wire logic [7:0] disk_err_code,
  input wire logic [3:0] disk_err_key,
  output logic dfl_sel,
  output logic [15:0] dfl_addr,
  input wire logic [7:0] dfl_data,
  input wire logic [15:0] dfl_plen,
  input wire logic [15:0] dfl_glen,
  input wire logic dfl_unreadable,
  input wire logic dfl_missing,
  output logic busy,
  output logic done,
  output logic [7:0] status,
  output logic sense_valid,
  output logic [3:0] sense_key,
  output logic [7:0] sense_code,
  output logic [31:0] sense_info
);
  sdb_pkg::sdb_state_t state_r;
  logic [15:0] idx_r;
  logic [31:0] lba_r;
  logic [31:0] left_r;
  logic [15:0] alloc_r;
  logic [15:0] lst_left_r;
  logic inv_r;
  logic mism_r;
  logic grown_pend_r;
  logic [159:0] phdr_r;
  logic mem_we_r;
  logic [AW-1:0] mem_waddr_r;
  logic [7:0] mem_wdata_r;
  logic [7:0] mem_rdata;
  logic out_rdy_r, in_valid_r, disk_req_r, disk_rdy_r, dfl_sel_r, busy_r, done_r;
  logic [7:0] in_byte_r, status_r, sense_code_r;
  logic [31:0] disk_lba_r, sense_info_r;
  logic [15:0] dfl_addr_r;
  logic sense_valid_r;
  logic [3:0] sense_key_r;

  logic out_take, load_ok, blk_end, m_nxt, hit_w;
  logic [15:0] patlen_nxt, hdr_len, blk_last;
  logic [7:0] hdr_byte;
  logic [7:0] op;
  logic [15:0] cdb_alloc;

  assign op = `SDB_CDB(cmd_cdb, 0);
  assign cdb_alloc = {`SDB_CDB(cmd_cdb, 7), `SDB_CDB(cmd_cdb, 8)};
  assign out_take = out_valid && out_rdy_r;
  assign load_ok = !in_valid_r || in_ready;
  assign blk_last = 16'(blk_size - 16'h0001);
  // a zero-length pattern ends right after header byte 19
  assign patlen_nxt = (idx_r == `SDB_PHDR_LAST) ? {phdr_r[7:0], out_byte}
                                                : phdr_r[`SDB_F_PATLEN];
  assign m_nxt = mism_r || (disk_byte != mem_rdata);
  assign blk_end = (state_r == sdb_pkg::SDB_CMP) && disk_valid && disk_rdy_r
                   && !disk_err && (idx_r == blk_last);
  assign hit_w = inv_r ? m_nxt : !m_nxt;
  assign hdr_len = dfl_sel_r ? dfl_glen : dfl_plen;

  always_comb
  begin
    case (idx_r[1:0])
      2'b00: hdr_byte = 8'h00;
      2'b01: hdr_byte = dfl_sel_r ? `SDB_HDR_G : `SDB_HDR_P;
      2'b10: hdr_byte = hdr_len[15:8];
      default: hdr_byte = hdr_len[7:0];
    endcase
  end

  sdb_mem #(.AW(AW), .DW(8)) u_mem (
    .mclk(mclk),
    .ce(ce),
    .we(mem_we_r),
    .waddr(mem_waddr_r),
    .wdata(mem_wdata_r),
    .raddr(idx_r[AW-1:0]),
    .rdata_r(mem_rdata)
  );

  // parameter header capture; the pattern itself goes to memory
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      phdr_r <= '0;
    else if (ce && state_r == sdb_pkg::SDB_PARM && out_take && idx_r < `SDB_PHDR_LEN)
      phdr_r <= {phdr_r[151:0], out_byte};
  end

  // memory write staging for pattern and buffer-write data
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      mem_we_r <= 1'b0;
      mem_waddr_r <= '0;
      mem_wdata_r <= 8'h00;
    end
    else if (ce)
    begin
      mem_we_r <= 1'b0;
      mem_wdata_r <= out_byte;
      if (out_take && state_r == sdb_pkg::SDB_PARM && idx_r >= `SDB_PHDR_LEN)
      begin
        mem_we_r <= 1'b1;
        mem_waddr_r <= AW'(idx_r - `SDB_PHDR_LEN);
      end
      if (out_take && state_r == sdb_pkg::SDB_WBUF && idx_r >= `SDB_HDR_BYTES)
      begin
        mem_we_r <= 1'b1;
        mem_waddr_r <= AW'(idx_r - `SDB_HDR_BYTES);
      end
    end
  end

  task automatic finish(input logic [7:0] st, input logic [3:0] key, input logic [7:0] code);
    done_r <= 1'b1;
    busy_r <= 1'b0;
    status_r <= st;
    sense_key_r <= key;
    sense_code_r <= code;
    out_rdy_r <= 1'b0;
    disk_rdy_r <= 1'b0;
    state_r <= sdb_pkg::SDB_IDLE;
  endtask : finish

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_r <= sdb_pkg::SDB_IDLE;
      idx_r <= 16'h0000;
      lba_r <= 32'h0000_0000;
      left_r <= 32'h0000_0000;
      alloc_r <= 16'h0000;
      lst_left_r <= 16'h0000;
      inv_r <= 1'b0;
      mism_r <= 1'b0;
      grown_pend_r <= 1'b0;
      out_rdy_r <= 1'b0;
      in_valid_r <= 1'b0;
      in_byte_r <= 8'h00;
      disk_req_r <= 1'b0;
      disk_lba_r <= 32'h0000_0000;
      disk_rdy_r <= 1'b0;
      dfl_sel_r <= 1'b0;
      dfl_addr_r <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      status_r <= `SDB_ST_GOOD;
      sense_valid_r <= 1'b0;
      sense_key_r <= `SDB_KEY_NONE;
      sense_code_r <= `SDB_SC_NONE;
      sense_info_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      done_r <= 1'b0;
      disk_req_r <= 1'b0;
      if (in_valid_r && in_ready)
        in_valid_r <= 1'b0;
      case (state_r)
        sdb_pkg::SDB_IDLE:
        begin
          if (cmd_start)
          begin
            busy_r <= 1'b1;
            idx_r <= 16'h0000;
            sense_valid_r <= 1'b0;
            sense_info_r <= 32'h0000_0000;
            // parity outranks everything else in the command block
            if (bus_par_err)
              finish(`SDB_ST_CHECK, `SDB_KEY_HW, `SDB_SC_PARITY);
            else if (`SDB_CDB(cmd_cdb, 1) >> 5 != 8'(`SDB_LUN_OWN))
              finish(`SDB_ST_CHECK, `SDB_KEY_ILL, `SDB_SC_BAD_LUN);
            else
            begin
              case (op)
                `SDB_OP_SEARCH:
                begin
                  inv_r <= `SDB_CDB(cmd_cdb, 1) >> `SDB_INV_BIT != 8'h00;
                  lba_r <= {`SDB_CDB(cmd_cdb, 2), `SDB_CDB(cmd_cdb, 3),
                            `SDB_CDB(cmd_cdb, 4), `SDB_CDB(cmd_cdb, 5)};
                  left_r <= {16'h0000, cdb_alloc};
                  if (cdb_alloc == 16'h0000)
                    finish(`SDB_ST_CHECK, `SDB_KEY_ILL, `SDB_SC_BAD_CDB);
                  else
                  begin
                    out_rdy_r <= 1'b1;
                    state_r <= sdb_pkg::SDB_PARM;
                  end
                end
                `SDB_OP_DEFECT:
                begin
                  dfl_sel_r <= !cmd_cdb[79-16-7+`SDB_P_BIT];
                  grown_pend_r <= cmd_cdb[79-16-7+`SDB_P_BIT]
                                  && cmd_cdb[79-16-7+`SDB_G_BIT];
                  alloc_r <= cdb_alloc;
                  if (cmd_cdb[79-16-5:79-16-7] != `SDB_FMT_INDEX
                      || !(cmd_cdb[79-16-7+`SDB_P_BIT] || cmd_cdb[79-16-7+`SDB_G_BIT]))
                    finish(`SDB_ST_CHECK, `SDB_KEY_ILL, `SDB_SC_BAD_CDB);
                  else if (dfl_unreadable)
                    finish(`SDB_ST_CHECK, `SDB_KEY_REC, `SDB_SC_DL_READ);
                  else if (dfl_missing)
                    finish(`SDB_ST_CHECK, `SDB_KEY_REC, `SDB_SC_DL_MISS);
                  else if (cdb_alloc == 16'h0000)
                    finish(`SDB_ST_GOOD, `SDB_KEY_NONE, `SDB_SC_NONE);
                  else
                    state_r <= sdb_pkg::SDB_DHDR;
                end
                `SDB_OP_WBUF:
                begin
                  alloc_r <= (cdb_alloc < BUF_BYTES) ? cdb_alloc : BUF_BYTES;
                  if (cdb_alloc == 16'h0000)
                    finish(`SDB_ST_GOOD, `SDB_KEY_NONE, `SDB_SC_NONE);
                  else
                  begin
                    out_rdy_r <= 1'b1;
                    state_r <= sdb_pkg::SDB_WBUF;
                  end
                end
                default:
                  finish(`SDB_ST_CHECK, `SDB_KEY_ILL, `SDB_SC_ILL_CMD);
              endcase
            end
          end
        end
        sdb_pkg::SDB_PARM:
        begin
          if (out_take)
          begin
            idx_r <= 16'(idx_r + 16'h0001);
            if (idx_r >= `SDB_PHDR_LAST && 16'(idx_r - `SDB_PHDR_LAST) == patlen_nxt)
            begin
              out_rdy_r <= 1'b0;
              state_r <= sdb_pkg::SDB_CHECK;
            end
          end
        end
        sdb_pkg::SDB_CHECK:
        begin
          // the device leans on the initiator for these, but refuses bad lists
          if (phdr_r[`SDB_F_RSIZE] != {16'h0000, blk_size}
              || phdr_r[`SDB_F_PATLEN] != blk_size
              || phdr_r[`SDB_F_OFFS] != 32'h0000_0000
              || phdr_r[`SDB_F_DISP] != 32'h0000_0000
              || phdr_r[`SDB_F_COUNT] == 32'h0000_0000
              || phdr_r[`SDB_F_ARGLEN] != 16'(phdr_r[`SDB_F_PATLEN] + `SDB_ARG_EXTRA))
            finish(`SDB_ST_CHECK, `SDB_KEY_ILL, `SDB_SC_BAD_PARM);
          else
          begin
            if (phdr_r[`SDB_F_COUNT] < left_r)
              left_r <= phdr_r[`SDB_F_COUNT];
            state_r <= sdb_pkg::SDB_REQ;
          end
        end
        sdb_pkg::SDB_REQ:
        begin
          disk_req_r <= 1'b1;
          disk_lba_r <= lba_r;
          idx_r <= 16'h0000;
          mism_r <= 1'b0;
          state_r <= sdb_pkg::SDB_FETCH;
        end
        sdb_pkg::SDB_FETCH:
        begin
          // memory read of pattern byte idx is issued this cycle; the registered data is ready in SDB_CMP
          disk_rdy_r <= 1'b1;
          state_r <= sdb_pkg::SDB_CMP;
        end
        sdb_pkg::SDB_CMP:
        begin
          if (disk_err)
            finish(`SDB_ST_CHECK, disk_err_key, disk_err_code);
          else if (disk_valid && disk_rdy_r)
          begin
            disk_rdy_r <= 1'b0;
            mism_r <= m_nxt;
            if (!blk_end)
            begin
              idx_r <= 16'(idx_r + 16'h0001);
              state_r <= sdb_pkg::SDB_FETCH;
            end
            else if (hit_w)
            begin
              finish(`SDB_ST_MET, `SDB_KEY_NONE, `SDB_SC_NONE);
              sense_valid_r <= 1'b1;
              sense_info_r <= lba_r;
            end
            else if (left_r == 32'h0000_0001)
              finish(`SDB_ST_GOOD, `SDB_KEY_NONE, `SDB_SC_NONE);
            else
            begin
              lba_r <= 32'(lba_r + 32'h0000_0001);
              left_r <= 32'(left_r - 32'h0000_0001);
              state_r <= sdb_pkg::SDB_REQ;
            end
          end
        end
        sdb_pkg::SDB_DHDR:
        begin
          if (load_ok)
          begin
            in_valid_r <= 1'b1;
            in_byte_r <= hdr_byte;
            alloc_r <= 16'(alloc_r - 16'h0001);
            idx_r <= 16'(idx_r + 16'h0001);
            lst_left_r <= hdr_len;
            dfl_addr_r <= 16'h0000;
            if (alloc_r == 16'h0001)
              state_r <= sdb_pkg::SDB_DRAIN;
            else if (idx_r == `SDB_HDR_LAST)
            begin
              if (hdr_len != 16'h0000)
                state_r <= sdb_pkg::SDB_DLIST;
              else if (grown_pend_r)
              begin
                dfl_sel_r <= 1'b1;
                grown_pend_r <= 1'b0;
                idx_r <= 16'h0000;
              end
              else
                state_r <= sdb_pkg::SDB_DRAIN;
            end
          end
        end
        sdb_pkg::SDB_DLIST:
        begin
          if (load_ok)
          begin
            in_valid_r <= 1'b1;
            in_byte_r <= dfl_data;
            alloc_r <= 16'(alloc_r - 16'h0001);
            lst_left_r <= 16'(lst_left_r - 16'h0001);
            dfl_addr_r <= 16'(dfl_addr_r + 16'h0001);
            if (alloc_r == 16'h0001)
              state_r <= sdb_pkg::SDB_DRAIN;
            else if (lst_left_r == 16'h0001)
            begin
              if (grown_pend_r)
              begin
                dfl_sel_r <= 1'b1;
                grown_pend_r <= 1'b0;
                idx_r <= 16'h0000;
                state_r <= sdb_pkg::SDB_DHDR;
              end
              else
                state_r <= sdb_pkg::SDB_DRAIN;
            end
          end
        end
        sdb_pkg::SDB_DRAIN:
        begin
          if (load_ok)
            finish(`SDB_ST_GOOD, `SDB_KEY_NONE, `SDB_SC_NONE);
        end
        sdb_pkg::SDB_WBUF:
        begin
          if (out_take)
          begin
            idx_r <= 16'(idx_r + 16'h0001);
            alloc_r <= 16'(alloc_r - 16'h0001);
            if (alloc_r == 16'h0001)
              finish(`SDB_ST_GOOD, `SDB_KEY_NONE, `SDB_SC_NONE);
          end
        end
        default:
          state_r <= sdb_pkg::SDB_IDLE;
      endcase
    end
  end

  assign out_rdy = out_rdy_r;
  assign in_valid = in_valid_r;
  assign in_byte = in_byte_r;
  assign disk_req = disk_req_r;
  assign disk_lba = disk_lba_r;
  assign disk_rdy = disk_rdy_r;
  assign dfl_sel = dfl_sel_r;
  assign dfl_addr = dfl_addr_r;
  assign busy = busy_r;
  assign done = done_r;
  assign status = status_r;
  assign sense_valid = sense_valid_r;
  assign sense_key = sense_key_r;
  assign sense_code = sense_code_r;
  assign sense_info = sense_info_r;

  sequence blk_hit_s;
    ce && blk_end && hit_w;
  endsequence
  sequence blk_miss_last_s;
    ce && blk_end && !hit_w && left_r == 32'h0000_0001;
  endsequence

  hit_met_a: assert property (@(posedge mclk) disable iff (!nrst)
    blk_hit_s |=> done_r && status_r == `SDB_ST_MET)
    else $error("search hit did not give condition met");
  hit_info_a: assert property (@(posedge mclk) disable iff (!nrst)
    blk_hit_s |=> sense_valid_r && sense_info_r == $past(lba_r))
    else $error("hit address not in sense");
  miss_end_a: assert property (@(posedge mclk) disable iff (!nrst)
    blk_miss_last_s |=> done_r && status_r == `SDB_ST_GOOD)
    else $error("exhausted search did not end with good status");
  miss_sense_a: assert property (@(posedge mclk) disable iff (!nrst)
    blk_miss_last_s |=> !sense_valid_r && sense_code_r == `SDB_SC_NONE)
    else $error("miss sense not cleared");
  dfl_hdr_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && state_r == sdb_pkg::SDB_DHDR && load_ok && idx_r == 16'h0001
    |=> in_valid_r && in_byte_r == ($past(dfl_sel_r) ? `SDB_HDR_G : `SDB_HDR_P))
    else $error("defect header flag byte wrong");
  dfl_alloc_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && (state_r == sdb_pkg::SDB_DHDR || state_r == sdb_pkg::SDB_DLIST)
    |-> alloc_r != 16'h0000)
    else $error("defect byte beyond allocation");
  dfl_key_a: assert property (@(posedge mclk) disable iff (!nrst)
    done_r && (sense_code_r == `SDB_SC_DL_READ || sense_code_r == `SDB_SC_DL_MISS)
    |-> sense_key_r == `SDB_KEY_REC && status_r == `SDB_ST_CHECK)
    else $error("defect error key wrong");
  parm_key_a: assert property (@(posedge mclk) disable iff (!nrst)
    done_r && (sense_code_r == `SDB_SC_BAD_PARM || sense_code_r == `SDB_SC_BAD_CDB
    || sense_code_r == `SDB_SC_BAD_LUN) |-> sense_key_r == `SDB_KEY_ILL)
    else $error("illegal request key wrong");
  wbuf_cap_a: assert property (@(posedge mclk) disable iff (!nrst)
    mem_we_r && $past(state_r) == sdb_pkg::SDB_WBUF
    |-> {3'b000, mem_waddr_r} < 16'(BUF_BYTES - `SDB_HDR_BYTES))
    else $error("buffer write beyond capacity");
  wbuf_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
    ce && state_r == sdb_pkg::SDB_IDLE && cmd_start && !bus_par_err
    && op == `SDB_OP_WBUF && cdb_alloc == 16'h0000 && `SDB_CDB(cmd_cdb, 1) >> 5 == 8'h00
    |=> done_r && status_r == `SDB_ST_GOOD && !out_rdy_r)
    else $error("zero length buffer write not good");
endmodule : sdb_cmd

// File: hw/sdb_mem.sv
module sdb_mem #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input wire logic mclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_r
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (ce)
    begin
      rdata_r <= mem[raddr];
    end
  end
endmodule : sdb_mem

// File: shared/sdb_consts.svh
`ifndef SDB_CONSTS_SVH
`define SDB_CONSTS_SVH
// Behaviour
// - invert clear: stop on first equal block, report status 04
// - invert bit (cdb byte 1 bit 4) stops on first unequal block, status 04
// - block count exhausted without hit reports no-sense status
// - search ends on hit or after min(record count, command block count)
// - after a hit, sense shows valid=1 and the hit block address
// - after a miss without error, sense code 00h and valid=0
// - parameter list: size, offset, count, arg length, displacement, pattern len, pattern
// - P returns primary list, G grown list, both return both
// - both lists: header byte1 bit4 + primary, then header bit3 + grown
// - defect allocation length from cdb bytes 7/8; zero moves nothing
// - defect transfer stops at allocation length or end of data
// - defect data is a four-byte header then descriptors
// - defect list unreadable 19h, not found 1Ch, sense key 1
// - parameter field error 26h, bad cdb argument 24h, sense key 5
// - bad logical unit 25h key 5; bus parity error 47h key 4
// - buffer write is opcode 3Bh, lun in byte 1, length in bytes 7/8
// - buffer write ends at allocation length or 8K, whichever first
// - buffer write with zero allocation length moves nothing, no error

`define SDB_OP_SEARCH 8'h31
`define SDB_OP_DEFECT 8'h37
`define SDB_OP_WBUF 8'h3B
`define SDB_ST_GOOD 8'h00
`define SDB_ST_CHECK 8'h02
`define SDB_ST_MET 8'h04
`define SDB_SC_NONE 8'h00
`define SDB_SC_DL_READ 8'h19
`define SDB_SC_DL_MISS 8'h1C
`define SDB_SC_ILL_CMD 8'h20
`define SDB_SC_BAD_CDB 8'h24
`define SDB_SC_BAD_LUN 8'h25
`define SDB_SC_BAD_PARM 8'h26
`define SDB_SC_PARITY 8'h47
`define SDB_KEY_NONE 4'h0
`define SDB_KEY_REC 4'h1
`define SDB_KEY_HW 4'h4
`define SDB_KEY_ILL 4'h5
// cdb byte n of the 80-bit command block, byte 0 in the top bits
`define SDB_CDB(c, n) c[79-8*(n) -: 8]
`define SDB_INV_BIT 4
`define SDB_P_BIT 4
`define SDB_G_BIT 3
`define SDB_FMT_INDEX 3'h4
`define SDB_HDR_P 8'h10
`define SDB_HDR_G 8'h08
`define SDB_LUN_OWN 3'h0
// parameter header: 20 bytes, byte 0 ends up in the top bits
`define SDB_PHDR_LAST 16'h0013
`define SDB_PHDR_LEN 16'h0014
`define SDB_F_RSIZE 159:128
`define SDB_F_OFFS 127:96
`define SDB_F_COUNT 95:64
`define SDB_F_ARGLEN 63:48
`define SDB_F_DISP 47:16
`define SDB_F_PATLEN 15:0
`define SDB_ARG_EXTRA 16'h0006
`define SDB_HDR_BYTES 16'h0004
`define SDB_HDR_LAST 16'h0003
`define SDB_BUF_BYTES 16'h2000
`endif

// File: shared/sdb_pkg.sv
package sdb_pkg;
  typedef enum logic [3:0] {
    SDB_IDLE  = 4'b0000,
    SDB_PARM  = 4'b0001,
    SDB_CHECK = 4'b0010,
    SDB_REQ   = 4'b0011,
    SDB_FETCH = 4'b0100,
    SDB_CMP   = 4'b0101,
    SDB_DHDR  = 4'b0110,
    SDB_DLIST = 4'b0111,
    SDB_DRAIN = 4'b1000,
    SDB_WBUF  = 4'b1001
  } sdb_state_t;
endpackage : sdb_pkg
